// >>> hw/kps_defines.svh
`ifndef KPS_DEFINES_SVH
`define KPS_DEFINES_SVH

// ----------------------------------------
// Clock and oscillator
// ----------------------------------------
`define KPS_CLK_HZ 40000000
`define KPS_OSC_HZ 38000
`define KPS_OSC_DIV (`KPS_CLK_HZ / `KPS_OSC_HZ)

// ----------------------------------------
// Scan and frame timing in oscillator periods, arming in shift clock edges
// ----------------------------------------
`define KPS_SCAN_TICKS 582
`define KPS_SLOT_TICKS 48
`define KPS_FRAME_DIV 384
`define KPS_ARM_EDGES 2

// ----------------------------------------
// Matrix and readout sizes
// ----------------------------------------
`define KPS_N_DRIVE 6
`define KPS_N_SENSE 5
`define KPS_READ_BITS 32

// ----------------------------------------
// Commands and control code
// ----------------------------------------
`define KPS_CMD_KEY_READ 8'h43
`define KPS_CTRL_RESET 8'h18
`define KPS_CTRL_BIAS 7
`define KPS_CTRL_S0 6
`define KPS_CTRL_S1 5
`define KPS_CTRL_K0 4
`define KPS_CTRL_K1 3
`define KPS_CTRL_P0 2
`define KPS_CTRL_P1 1
`define KPS_CTRL_BLANK 0

`endif

// >>> hw/kps_pkg.sv
package kps_pkg;

  // ----------------------------------------
  // State encodings
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    SC_IDLE  = 3'h1,
    SC_RUN   = 3'h2,
    SC_JUDGE = 3'h4
  } kps_scan_e;

  typedef enum logic [2:0]
  {
    SR_CMD   = 3'h1,
    SR_WRITE = 3'h2,
    SR_READ  = 3'h4
  } kps_ser_e;

endpackage

// >>> hw/kps_fifo2.sv
`timescale 1ns/10ps

module kps_fifo2
#(
  parameter int W = 30,
  parameter int DEPTH = 2
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1)
    begin : g_bad_param
      $error("kps_fifo2: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } kps_fifo_s;

  kps_fifo_s r;
  kps_fifo_s n;
  logic push;
  logic pop;

  assign in_ready_o = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (r.cnt != '0);
  assign out_data_o = r.mem[r.rd];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_ready_i & out_valid_o;

  always_comb
  begin
    n = r;
    if (push)
    begin
      n.mem[r.wr] = in_data_i;
      n.wr = r.wr + AW'(1);
    end
    if (pop)
    begin
      n.rd = r.rd + AW'(1);
    end
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_i)
    begin
      n.wr = '0;
      n.rd = '0;
      n.cnt = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

endmodule

// >>> hw/kps_top.sv
`timescale 1ns/10ps
`include "kps_defines.svh"

module kps_top
#(
  parameter int N_DRIVE = `KPS_N_DRIVE,
  parameter int N_SENSE = `KPS_N_SENSE,
  parameter int OSC_DIV = `KPS_OSC_DIV,
  parameter int SCAN_TICKS = `KPS_SCAN_TICKS,
  parameter int SLOT_TICKS = `KPS_SLOT_TICKS
)
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // Serial command pins
  input wire logic CS_I,
  input wire logic SHIFT_CLOCK_INPUT_I,
  input wire logic SERIAL_DATA_INPUT_I,
  // Display reset pin
  input wire logic LCD_RST_N_I,
  // Key data open-drain pin
  output logic KEY_DO_O,
  output logic KEY_DO_OE_O,
  // Key matrix
  output logic [N_DRIVE-1:0] SCAN_DRIVE_LINE_O,
  input wire logic [N_SENSE-1:0] SCAN_SENSE_LINE_I,
  // Control bits
  output logic BIAS_SELECT_BIT_O,
  output logic SLEEP_SELECT_LO_O,
  output logic SLEEP_SELECT_HI_O,
  output logic KEYSEG_SELECT_LO_O,
  output logic KEYSEG_SELECT_HI_O,
  output logic EXPANSION_SELECT_LO_O,
  output logic EXPANSION_SELECT_HI_O,
  output logic DISPLAY_BLANK_BIT_O,
  // Display status
  output logic DISPLAY_ON_O,
  output logic OSC_RUN_O,
  output logic FRAME_TICK_O
);

  import kps_pkg::*;

  localparam int NK = N_DRIVE * N_SENSE;
  localparam int TAIL = SCAN_TICKS - 2 * N_DRIVE * SLOT_TICKS;
  localparam int DW = $clog2(OSC_DIV);
  localparam int SW = $clog2(SLOT_TICKS);
  localparam int TW = $clog2(TAIL + 1);
  localparam int FW = $clog2(`KPS_FRAME_DIV);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  generate
    if (N_DRIVE != 6 || N_SENSE != 5 || OSC_DIV < 2 || SLOT_TICKS < 2 || TAIL < 1)
    begin : g_bad_param
      $error("kps_top: matrix must be 6x5 and scan timing must leave a tail");
    end
  endgenerate

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic sdi_s1;
    logic sdi_s2;
    logic [N_SENSE-1:0] sen_s1;
    logic [N_SENSE-1:0] sen_s2;
    logic lrst_s1;
    logic lrst_s2;
    logic [7:0] ctrl;
    kps_ser_e ser;
    logic [7:0] cmd_sh;
    logic [7:0] ctrl_sh;
    logic [3:0] wr_cnt;
    logic [`KPS_READ_BITS-1:0] out_sh;
    logic [5:0] bit_cnt;
    logic do_bit;
    logic do_oe;
    logic had_key;
    logic [1:0] arm_cnt;
    logic [DW-1:0] osc_div;
    logic [FW-1:0] frame_cnt;
    logic frame_tick;
    kps_scan_e scan;
    logic [SW-1:0] slot_cnt;
    logic [2:0] line;
    logic pass;
    logic [TW-1:0] tail_cnt;
    logic [NK-1:0] map_a;
    logic [NK-1:0] map_b;
    logic [N_DRIVE-1:0] drive;
    logic disp_on;
  } kps_top_s;

  kps_top_s r;
  kps_top_s n;

  logic cs_rise;
  logic cs_fall;
  logic sck_rise;
  logic sleep;
  logic osc_run;
  logic osc_tick;
  logic armed;
  logic [N_DRIVE-1:0] line_en;
  logic [N_DRIVE-1:0] standby;
  logic [N_SENSE-1:0] sense_val;
  logic [4:0] map_base;
  logic slot_end;
  logic judge_end;
  logic maps_match;
  logic push_valid;
  logic push_ready;
  logic pop_ready;
  logic key_valid;
  logic [NK-1:0] key_data;

  // ----------------------------------------
  // Edges and decoded control
  // ----------------------------------------
  assign cs_rise = r.cs_s2 & ~r.cs_s3;
  assign cs_fall = ~r.cs_s2 & r.cs_s3;
  assign sck_rise = r.sck_s2 & ~r.sck_s3;
  assign sleep = r.ctrl[`KPS_CTRL_S0] | r.ctrl[`KPS_CTRL_S1];
  assign armed = (r.arm_cnt == 2'(`KPS_ARM_EDGES));
  assign osc_run = ~sleep | (r.scan != SC_IDLE);
  assign osc_tick = osc_run & (r.osc_div == DW'(OSC_DIV - 1));
  assign slot_end = osc_tick & (r.slot_cnt == SW'(SLOT_TICKS - 1));
  assign judge_end = osc_tick & (r.tail_cnt == TW'(TAIL - 1));
  assign maps_match = (r.map_a == r.map_b);
  assign map_base = 5'(r.line) * 5'h5;
  assign sense_val = r.sen_s2 & {N_SENSE{line_en[r.line]}};

  // Drive lines given over to segments carry no keys
  always_comb
  begin
    line_en = '1;
    if (r.ctrl[`KPS_CTRL_K0])
    begin
      line_en[1:0] = 2'h0;
    end
    else if (r.ctrl[`KPS_CTRL_K1])
    begin
      line_en[0] = 1'b0;
    end
  end

  // Standby level of the drive lines per sleep mode
  always_comb
  begin
    case ({r.ctrl[`KPS_CTRL_S0], r.ctrl[`KPS_CTRL_S1]})
      2'h1: standby = 6'h20;
      2'h2: standby = 6'h30;
      default: standby = 6'h3F;
    endcase
  end

  // ----------------------------------------
  // Key buffer
  // ----------------------------------------
  assign push_valid = (r.scan == SC_JUDGE) & judge_end & maps_match & (|r.map_b);

  kps_fifo2
  #(
    .W(NK),
    .DEPTH(2)
  )
  u_key_buf
  (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .flush_i(~r.lrst_s2),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(r.map_b),
    .out_valid_o(key_valid),
    .out_ready_i(pop_ready),
    .out_data_o(key_data)
  );

  assign pop_ready = (r.ser == SR_READ) & sck_rise & r.had_key & (r.bit_cnt == 6'(`KPS_READ_BITS - 1));

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    n = r;
    n.cs_s1 = CS_I;
    n.cs_s2 = r.cs_s1;
    n.cs_s3 = r.cs_s2;
    n.sck_s1 = SHIFT_CLOCK_INPUT_I;
    n.sck_s2 = r.sck_s1;
    n.sck_s3 = r.sck_s2;
    n.sdi_s1 = SERIAL_DATA_INPUT_I;
    n.sdi_s2 = r.sdi_s1;
    n.sen_s1 = SCAN_SENSE_LINE_I;
    n.sen_s2 = r.sen_s1;
    n.lrst_s1 = LCD_RST_N_I;
    n.lrst_s2 = r.lrst_s1;

    if (sck_rise && !armed)
    begin
      n.arm_cnt = r.arm_cnt + 2'h1;
    end

    // Serial command port
    case (r.ser)
      SR_CMD:
      begin
        if (sck_rise)
        begin
          n.cmd_sh = {r.cmd_sh[6:0], r.sdi_s2};
        end
        if (cs_rise)
        begin
          if (r.cmd_sh == `KPS_CMD_KEY_READ)
          begin
            n.ser = SR_READ;
            n.out_sh = {sleep, 1'b0, key_valid ? key_data : {NK{1'b0}}};
            n.had_key = key_valid;
            n.bit_cnt = '0;
            n.do_bit = 1'b1;
          end
          else
          begin
            n.ser = SR_WRITE;
            n.wr_cnt = '0;
          end
        end
      end
      SR_WRITE:
      begin
        if (sck_rise)
        begin
          n.ctrl_sh = {r.ctrl_sh[6:0], r.sdi_s2};
          if (r.wr_cnt != 4'h8)
          begin
            n.wr_cnt = r.wr_cnt + 4'h1;
          end
        end
        if (cs_fall)
        begin
          if (r.wr_cnt == 4'h8)
          begin
            n.ctrl = r.ctrl_sh;
          end
          n.ser = SR_CMD;
          n.cmd_sh = '0;
        end
      end
      SR_READ:
      begin
        if (sck_rise && r.bit_cnt != 6'(`KPS_READ_BITS))
        begin
          n.do_bit = r.out_sh[0];
          n.out_sh = {1'b1, r.out_sh[`KPS_READ_BITS-1:1]};
          n.bit_cnt = r.bit_cnt + 6'h1;
        end
        if (cs_fall)
        begin
          n.ser = SR_CMD;
          n.cmd_sh = '0;
          n.do_bit = 1'b1;
        end
      end
      default:
      begin
        n.ser = SR_CMD;
      end
    endcase

    // Display oscillator and frame rate
    if (osc_run)
    begin
      n.osc_div = osc_tick ? '0 : r.osc_div + DW'(1);
    end
    n.frame_tick = 1'b0;
    if (osc_tick)
    begin
      if (r.frame_cnt == FW'(`KPS_FRAME_DIV - 1))
      begin
        n.frame_cnt = '0;
        n.frame_tick = 1'b1;
      end
      else
      begin
        n.frame_cnt = r.frame_cnt + FW'(1);
      end
    end

    // Key scanner
    case (r.scan)
      SC_IDLE:
      begin
        n.drive = standby & line_en;
        if (armed && (|r.sen_s2) && !key_valid && push_ready && r.lrst_s2 && (osc_tick || !osc_run))
        begin
          n.scan = SC_RUN;
          n.osc_div = '0;
          n.slot_cnt = '0;
          n.line = '0;
          n.pass = 1'b0;
          n.map_a = '0;
          n.map_b = '0;
          n.drive = line_en & N_DRIVE'(1);
        end
      end
      SC_RUN:
      begin
        if (osc_tick)
        begin
          n.slot_cnt = r.slot_cnt + SW'(1);
        end
        if (slot_end)
        begin
          n.slot_cnt = '0;
          if (r.pass)
          begin
            n.map_b[map_base +: N_SENSE] = sense_val;
          end
          else
          begin
            n.map_a[map_base +: N_SENSE] = sense_val;
          end
          if (r.line == 3'(N_DRIVE - 1))
          begin
            n.line = '0;
            n.pass = ~r.pass;
            if (r.pass)
            begin
              n.scan = SC_JUDGE;
              n.tail_cnt = '0;
            end
          end
          else
          begin
            n.line = r.line + 3'h1;
          end
          n.drive = (n.scan == SC_RUN) ? (line_en & (N_DRIVE'(1) << n.line)) : (standby & line_en);
        end
      end
      SC_JUDGE:
      begin
        n.drive = standby & line_en;
        if (osc_tick)
        begin
          n.tail_cnt = r.tail_cnt + TW'(1);
        end
        if (judge_end)
        begin
          n.scan = SC_IDLE;
          n.drive = standby & line_en;
          if (!maps_match && (|r.sen_s2))
          begin
            n.scan = SC_RUN;
            n.slot_cnt = '0;
            n.line = '0;
            n.pass = 1'b0;
            n.map_a = '0;
            n.map_b = '0;
            n.drive = line_en & N_DRIVE'(1);
          end
        end
      end
      default:
      begin
        n.scan = SC_IDLE;
      end
    endcase

    // Open-drain key output and display enable
    n.do_oe = (n.ser == SR_READ) ? ~n.do_bit : key_valid;
    n.disp_on = ~r.ctrl[`KPS_CTRL_BLANK] & ~sleep & r.lrst_s2;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      r <= '0;
      r.ctrl <= `KPS_CTRL_RESET;
      r.ser <= SR_CMD;
      r.scan <= SC_IDLE;
      r.do_bit <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign KEY_DO_O = 1'b0;
  assign KEY_DO_OE_O = r.do_oe;
  assign SCAN_DRIVE_LINE_O = r.drive;
  assign BIAS_SELECT_BIT_O = r.ctrl[`KPS_CTRL_BIAS];
  assign SLEEP_SELECT_LO_O = r.ctrl[`KPS_CTRL_S0];
  assign SLEEP_SELECT_HI_O = r.ctrl[`KPS_CTRL_S1];
  assign KEYSEG_SELECT_LO_O = r.ctrl[`KPS_CTRL_K0];
  assign KEYSEG_SELECT_HI_O = r.ctrl[`KPS_CTRL_K1];
  assign EXPANSION_SELECT_LO_O = r.ctrl[`KPS_CTRL_P0];
  assign EXPANSION_SELECT_HI_O = r.ctrl[`KPS_CTRL_P1];
  assign DISPLAY_BLANK_BIT_O = r.ctrl[`KPS_CTRL_BLANK];
  assign DISPLAY_ON_O = r.disp_on;
  assign OSC_RUN_O = osc_run;
  assign FRAME_TICK_O = r.frame_tick;

endmodule

// >>> test/kps_chk.sv
`timescale 1ns/10ps

module kps_chk
#(
  parameter int N_DRIVE = 6,
  parameter int OSC_DIV = 4,
  parameter int SLOT_TICKS = 4
)
(
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic CS_I,
  input wire logic LCD_RST_N_I,
  input wire logic KEY_DO_O,
  input wire logic KEY_DO_OE_O,
  input wire logic [N_DRIVE-1:0] SCAN_DRIVE_LINE_O,
  input wire logic BIAS_SELECT_BIT_O,
  input wire logic SLEEP_SELECT_LO_O,
  input wire logic SLEEP_SELECT_HI_O,
  input wire logic KEYSEG_SELECT_LO_O,
  input wire logic KEYSEG_SELECT_HI_O,
  input wire logic EXPANSION_SELECT_LO_O,
  input wire logic EXPANSION_SELECT_HI_O,
  input wire logic DISPLAY_BLANK_BIT_O,
  input wire logic DISPLAY_ON_O,
  input wire logic OSC_RUN_O,
  input wire logic FRAME_TICK_O
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  localparam int SLOT_CYC = SLOT_TICKS * OSC_DIV;
  localparam int FRAME_CYC = 384 * OSC_DIV;
  logic [N_DRIVE-1:0] dprev_r;
  int hold_r;
  int fcnt_r;
  logic fseen_r;
  logic frun_r;
  logic sleep;
  logic [7:0] ctrl;

  assign sleep = SLEEP_SELECT_LO_O | SLEEP_SELECT_HI_O;
  assign ctrl = {BIAS_SELECT_BIT_O, SLEEP_SELECT_LO_O, SLEEP_SELECT_HI_O, KEYSEG_SELECT_LO_O,
                 KEYSEG_SELECT_HI_O, EXPANSION_SELECT_LO_O, EXPANSION_SELECT_HI_O, DISPLAY_BLANK_BIT_O};

  always_ff @(posedge CLOCK_I)
  begin
    dprev_r <= SCAN_DRIVE_LINE_O;
    hold_r <= (SCAN_DRIVE_LINE_O != dprev_r) ? 1 : hold_r + 1;
    if (!RST_N_I)
    begin
      fcnt_r <= 0;
      fseen_r <= 1'b0;
      frun_r <= 1'b0;
    end
    else if (FRAME_TICK_O)
    begin
      fcnt_r <= 1;
      fseen_r <= 1'b1;
      frun_r <= OSC_RUN_O;
    end
    else
    begin
      fcnt_r <= fcnt_r + 1;
      frun_r <= frun_r & OSC_RUN_O;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_CTRL_RESET: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    $rose(RST_N_I) |-> ctrl == 8'h18) else $error("control bits not at reset value");
  AST_BLANK_DARK: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    DISPLAY_BLANK_BIT_O && $past(DISPLAY_BLANK_BIT_O) |-> !DISPLAY_ON_O) else $error("display on while blanked");
  AST_SLEEP_DARK: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    sleep && $past(sleep) |-> !DISPLAY_ON_O) else $error("display on in sleep");
  AST_LCD_DARK: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (!LCD_RST_N_I) [*5] |-> !DISPLAY_ON_O) else $error("display on during display reset");
  AST_PIN_VALUE: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    KEY_DO_O == 1'b0) else $error("open drain value not low");
  AST_SLOT_LEN: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    SCAN_DRIVE_LINE_O != dprev_r && SCAN_DRIVE_LINE_O == (dprev_r << 1) |-> hold_r == SLOT_CYC)
    else $error("scan slot length wrong");
  AST_FRAME_RATE: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    FRAME_TICK_O && fseen_r && frun_r |-> fcnt_r == FRAME_CYC) else $error("frame period wrong");
  AST_PENDING_HOLD: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    KEY_DO_OE_O && $past(KEY_DO_OE_O) && !CS_I && !$past(CS_I, 8) |-> $stable(SCAN_DRIVE_LINE_O))
    else $error("scan while key word pending");
  AST_OSC_NORMAL: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    !sleep |-> OSC_RUN_O) else $error("oscillator stopped in normal mode");
  AST_OSC_SCAN: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    sleep && SCAN_DRIVE_LINE_O == N_DRIVE'(1) |-> OSC_RUN_O) else $error("oscillator stopped during scan");
endmodule

bind kps_top kps_chk #(.N_DRIVE(N_DRIVE), .OSC_DIV(OSC_DIV), .SLOT_TICKS(SLOT_TICKS)) chk (
  .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .CS_I(CS_I), .LCD_RST_N_I(LCD_RST_N_I), .KEY_DO_O(KEY_DO_O),
  .KEY_DO_OE_O(KEY_DO_OE_O), .SCAN_DRIVE_LINE_O(SCAN_DRIVE_LINE_O), .BIAS_SELECT_BIT_O(BIAS_SELECT_BIT_O),
  .SLEEP_SELECT_LO_O(SLEEP_SELECT_LO_O), .SLEEP_SELECT_HI_O(SLEEP_SELECT_HI_O),
  .KEYSEG_SELECT_LO_O(KEYSEG_SELECT_LO_O), .KEYSEG_SELECT_HI_O(KEYSEG_SELECT_HI_O),
  .EXPANSION_SELECT_LO_O(EXPANSION_SELECT_LO_O), .EXPANSION_SELECT_HI_O(EXPANSION_SELECT_HI_O),
  .DISPLAY_BLANK_BIT_O(DISPLAY_BLANK_BIT_O), .DISPLAY_ON_O(DISPLAY_ON_O), .OSC_RUN_O(OSC_RUN_O),
  .FRAME_TICK_O(FRAME_TICK_O));

// >>> test/kps_host.sv
`timescale 1ns/10ps

module kps_host
(
  // Clock
  input wire logic clk_i,
  // Key data pin enable
  input wire logic oe_i,
  // Serial pins
  output logic cs_o,
  output logic sck_o,
  output logic sdi_o,
  // Received key word
  output logic [31:0] word_o,
  output logic stb_o
);
  initial
  begin
    cs_o = 1'b0;
    sck_o = 1'b0;
    sdi_o = 1'b0;
    word_o = '0;
    stb_o = 1'b0;
  end

  // ----------------------------------------
  // Serial frames
  // ----------------------------------------
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic rise();
    sck_o <= 1'b1;
    hold(4);
    sck_o <= 1'b0;
    hold(4);
  endtask

  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sdi_o <= b[i];
      hold(4);
      sck_o <= 1'b1;
      hold(4);
      sck_o <= 1'b0;
    end
  endtask

  task automatic write_ctrl(input logic [7:0] c);
    send(8'h80);
    cs_o <= 1'b1;
    hold(4);
    send(c);
    cs_o <= 1'b0;
    hold(4);
    repeat (2) rise();
  endtask

  task automatic read_keys();
    logic [31:0] w;
    send(8'h43);
    cs_o <= 1'b1;
    hold(8);
    for (int i = 0; i < 32; i++)
    begin
      sck_o <= 1'b1;
      hold(4);
      sck_o <= 1'b0;
      hold(3);
      w[i] = !oe_i;
      hold(1);
    end
    cs_o <= 1'b0;
    word_o <= w;
    stb_o <= 1'b1;
    hold(1);
    stb_o <= 1'b0;
    hold(8);
    repeat (2) rise();
  endtask
endmodule

// >>> test/kps_top_tb_top.sv
`timescale 1ns/10ps

module kps_top_tb_top;
  logic clk;
  logic rst_n;
  logic lcd_rst_n;
  logic cs;
  logic sck;
  logic sdi;
  logic oe;
  logic [5:0] drv;
  logic [4:0] sense;
  logic [7:0] ctrl;
  logic disp_on;
  logic osc_run;
  logic key_do;
  logic frame_tick;
  logic [29:0] keys;
  logic [29:0] a;
  logic [29:0] b;
  logic [31:0] rx_word;
  logic rx_stb;
  logic [31:0] exp_q[$];
  int bad_count;
  int num_checks;

  // ----------------------------------------
  // Key matrix and instances
  // ----------------------------------------
  function automatic logic [4:0] sns(input logic [29:0] k, input logic [5:0] d);
    sns = '0;
    for (int n = 0; n < 30; n++)
      if (k[n] && d[n / 5])
        sns[n % 5] = 1'b1;
  endfunction

  assign sense = sns(keys, drv);
  always #12.5 clk = ~clk;

  kps_top #(.OSC_DIV(4), .SLOT_TICKS(4), .SCAN_TICKS(54)) uut (
    .CLOCK_I(clk), .RST_N_I(rst_n), .CS_I(cs), .SHIFT_CLOCK_INPUT_I(sck), .SERIAL_DATA_INPUT_I(sdi),
    .LCD_RST_N_I(lcd_rst_n), .KEY_DO_O(key_do), .KEY_DO_OE_O(oe), .SCAN_DRIVE_LINE_O(drv),
    .SCAN_SENSE_LINE_I(sense), .BIAS_SELECT_BIT_O(ctrl[7]), .SLEEP_SELECT_LO_O(ctrl[6]),
    .SLEEP_SELECT_HI_O(ctrl[5]), .KEYSEG_SELECT_LO_O(ctrl[4]), .KEYSEG_SELECT_HI_O(ctrl[3]),
    .EXPANSION_SELECT_LO_O(ctrl[2]), .EXPANSION_SELECT_HI_O(ctrl[1]), .DISPLAY_BLANK_BIT_O(ctrl[0]),
    .DISPLAY_ON_O(disp_on), .OSC_RUN_O(osc_run), .FRAME_TICK_O(frame_tick));

  kps_host host (.clk_i(clk), .oe_i(oe), .cs_o(cs), .sck_o(sck), .sdi_o(sdi), .word_o(rx_word), .stb_o(rx_stb));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic waitoe(input int lim);
    for (int i = 0; i < lim && oe !== 1'b1; i++)
      @(posedge clk);
    if (oe !== 1'b1)
    begin
      bad_count++;
      conclude();
    end
  endtask

  task automatic frame_gap();
    int c;
    c = 0;
    for (int i = 0; i < 2000 && frame_tick !== 1'b1; i++)
      @(posedge clk);
    @(posedge clk);
    while (c < 2000 && frame_tick !== 1'b1)
    begin
      c++;
      @(posedge clk);
    end
    check(c + 1, 384 * 4);
  endtask

  task automatic rd(input logic [31:0] e);
    exp_q.push_back(e);
    host.read_keys();
  endtask

  always @(posedge clk)
    if (rx_stb === 1'b1)
      check(rx_word, exp_q.pop_front());

  initial
  begin
    repeat (100000) @(posedge clk);
    bad_count++;
    conclude();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    lcd_rst_n = 1'b0;
    keys = '0;
    bad_count = 0;
    num_checks = 0;
    void'($urandom(32'hC827B921));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check(ctrl, 8'h18);
    keys <= 30'h400;
    repeat (40000) @(posedge clk);
    check(disp_on, 1'b0);
    lcd_rst_n <= 1'b1;
    repeat (300) @(posedge clk);
    check(oe, 1'b0);
    lcd_rst_n <= 1'b0;
    host.write_ctrl(8'h00);
    check(ctrl, 8'h00);
    check(disp_on, 1'b0);
    lcd_rst_n <= 1'b1;
    waitoe(600);
    check(key_do, 1'b0);
    keys <= '0;
    rd({2'b00, 30'h400});
    check(disp_on, 1'b1);
    frame_gap();
    host.write_ctrl(8'h01);
    check(disp_on, 1'b0);
    host.write_ctrl(8'h00);
    check(disp_on, 1'b1);
    repeat (3)
    begin
      a = 30'($urandom) | 30'h1;
      b = ~a | 30'h2;
      keys <= a;
      waitoe(600);
      keys <= b;
      repeat (300) @(posedge clk);
      check(oe, 1'b1);
      rd({2'b00, a});
      waitoe(600);
      keys <= '0;
      rd({2'b00, b});
    end
    keys <= 30'h1;
    for (int i = 0; i < 400 && drv !== 6'h08; i++)
      @(posedge clk);
    if (drv !== 6'h08)
    begin
      bad_count++;
      conclude();
    end
    keys <= 30'h2;
    waitoe(1500);
    keys <= '0;
    rd({2'b00, 30'h2});
    host.write_ctrl(8'h20);
    check(drv, 6'h20);
    check(osc_run, 1'b0);
    keys <= 30'h1;
    repeat (300) @(posedge clk);
    check(oe, 1'b0);
    keys <= 30'h2000000;
    waitoe(600);
    keys <= '0;
    rd({2'b10, 30'h2000000});
    check(osc_run, 1'b0);
    conclude();
  end
endmodule
